//--- rtl/imsm_device.sv
/*
 imsm_device: sampling schedule, filters and serial message framer of the unit.
 assumes sensor words arrive on clk; pins from the host are asynchronous.
*/
// What this block does
// - send bytes at 460,800 baud, NRZ
// - start bit 0, eight data, two stops
// - multi-byte values most significant byte first
// - 200 messages per second while enabled
// - 34 words, 68 bytes, fixed order
// - gate high or floating means continuous output
// - gate low stops output after current message
// - reset pin active low holds unit
// - 1 kHz sampling, strobe high while sampling
// - second-order low-pass per sample, corner above 85Hz
// - five-cycle schedule, compensation cycles 2, 3
// - message starts after fifth-cycle strobe falls
// - message carries cycle-three data
// - last word is negated 16-bit sum
`timescale 1ns/10ps
`default_nettype none
module imsm_device #(
    parameter int unsigned PERIOD_CYCLES = imsm_pkg::SAMPLE_PERIOD_CYCLES,
    parameter int unsigned STROBE_LEN = imsm_pkg::STROBE_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // sensor side
    input wire logic [imsm_pkg::CHANNELS-1:0][15:0] sensor_in,
    input wire logic [15:0] comp_bias,
    input wire logic [imsm_pkg::FLAG_WORDS-1:0][15:0] flag_words,
    output logic [2:0] slot,
    output logic sending,
    // pins
    imsm_link_if.device link
);
    typedef struct packed {
        logic [2:0] gate_sync;
        logic gate_en;
        logic [2:0] rst_sync;
        logic run;
        logic [16:0] phase;
        logic [2:0] slot;
        logic strobe;
        logic [imsm_pkg::CHANNELS-1:0][15:0] raw;
        logic [imsm_pkg::CHANNELS-1:0][15:0] stage1;
        logic [imsm_pkg::CHANNELS-1:0][15:0] stage2;
        logic [15:0] comp;
        logic [imsm_pkg::CHANNELS-1:0][15:0] snap;
        logic [imsm_pkg::CHANNELS-1:0][15:0] msg_data;
        logic [imsm_pkg::FLAG_WORDS-1:0][15:0] msg_flags;
        logic [15:0] count;
        logic busy;
        logic [6:0] byte_idx;
        logic [3:0] bit_idx;
        logic [8:0] baud;
        logic tx_line;
    } imsm_dev_type;

    localparam imsm_dev_type IDLE_STATE = '{
        gate_sync: 3'h7, gate_en: 1'b1, rst_sync: 3'h0, run: 1'b0,
        phase: 17'h0, slot: imsm_pkg::SLOT_FIRST, strobe: 1'b0,
        raw: '0, stage1: '0, stage2: '0, comp: 16'h0, snap: '0,
        msg_data: '0, msg_flags: '0, count: 16'h0, busy: 1'b0,
        byte_idx: 7'h0, bit_idx: 4'h0, baud: 9'h0, tx_line: 1'b1};

    imsm_dev_type s;
    imsm_dev_type next_s;
    logic [imsm_pkg::CHANNELS-1:0][15:0] filt1;
    logic [imsm_pkg::CHANNELS-1:0][15:0] filt2;
    logic [imsm_pkg::MSG_WORDS-1:0][15:0] words;
    logic [15:0] sum;
    logic [15:0] cur_word;
    logic [7:0] cur_byte;

    // two cascaded 3/4-weight sections form the second-order low-pass
    // half weight alone would put the corner near 73 Hz
    genvar ch;
    generate
        for (ch = 0; ch < imsm_pkg::CHANNELS; ch++) begin : g_filter
            logic [16:0] diff1;
            logic [16:0] diff2;
            assign diff1 = {s.raw[ch][15], s.raw[ch]} - {s.stage1[ch][15], s.stage1[ch]};
            assign filt1[ch] = s.stage1[ch]
                + 16'($signed(diff1) >>> imsm_pkg::FILTER_SHIFT)
                + 16'($signed(diff1) >>> (imsm_pkg::FILTER_SHIFT + 1));
            assign diff2 = {filt1[ch][15], filt1[ch]} - {s.stage2[ch][15], s.stage2[ch]};
            assign filt2[ch] = s.stage2[ch]
                + 16'($signed(diff2) >>> imsm_pkg::FILTER_SHIFT)
                + 16'($signed(diff2) >>> (imsm_pkg::FILTER_SHIFT + 1));
        end
    endgenerate

    always_comb begin
        // message image, fixed word order
        words = '0;
        words[0] = imsm_pkg::HEADER;
        words[1] = s.count;
        for (int i = 0; i < imsm_pkg::CHANNELS; i++) begin
            // 32-bit item, high word first
            words[imsm_pkg::DATA_FIRST_WORD + 2 * i] = {16{s.msg_data[i][15]}};
            words[imsm_pkg::DATA_FIRST_WORD + 2 * i + 1] = s.msg_data[i];
        end
        for (int i = 0; i < imsm_pkg::FLAG_WORDS; i++) begin
            words[imsm_pkg::FLAG_FIRST_WORD + i] = s.msg_flags[i];
        end
        sum = 16'h0;
        for (int i = 0; i < imsm_pkg::MSG_WORDS - 1; i++) begin
            sum = sum + words[i];
        end
        words[imsm_pkg::MSG_WORDS-1] = 16'h0 - sum;
        cur_word = words[s.byte_idx[6:1]];
        cur_byte = s.byte_idx[0] ? cur_word[7:0] : cur_word[15:8];

        next_s = s;
        // pins: three flops, change taken once last two agree
        next_s.gate_sync = {s.gate_sync[1:0], link.gate_level};
        if (s.gate_sync[2] == s.gate_sync[1]) begin
            next_s.gate_en = s.gate_sync[2];
        end
        next_s.rst_sync = {s.rst_sync[1:0], link.reset_pin_n};
        if (s.rst_sync[2] == s.rst_sync[1]) begin
            next_s.run = s.rst_sync[2];
        end

        // 1 kHz schedule
        if (s.phase == 17'(PERIOD_CYCLES - 1)) begin
            next_s.phase = 17'h0;
            next_s.slot = (s.slot == imsm_pkg::SLOT_TRANSMIT) ? imsm_pkg::SLOT_FIRST
                : s.slot + 3'h1;
        end else begin
            next_s.phase = s.phase + 17'h1;
        end
        next_s.strobe = next_s.phase < 17'(STROBE_LEN);
        if (s.phase == 17'h0) begin
            next_s.raw = sensor_in;
        end
        if (s.phase == 17'(STROBE_LEN)) begin
            next_s.stage1 = filt1;
            next_s.stage2 = filt2;
            if (s.slot == imsm_pkg::SLOT_COMP_CALC) begin
                next_s.comp = comp_bias;
            end
            if (s.slot == imsm_pkg::SLOT_COMP_APPLY) begin
                for (int i = 0; i < imsm_pkg::CHANNELS; i++) begin
                    next_s.snap[i] = filt2[i] + s.comp;
                end
            end
            // start only after fifth strobe is low, gate sampled here
            if (s.slot == imsm_pkg::SLOT_TRANSMIT && s.gate_en && !s.busy) begin
                next_s.busy = 1'b1;
                next_s.byte_idx = 7'h0;
                next_s.bit_idx = 4'h0;
                next_s.baud = 9'h0;
                next_s.msg_data = s.snap;
                next_s.msg_flags = flag_words;
            end
        end

        // byte framer; gate drop never cuts a message short
        if (s.busy) begin
            if (s.baud == 9'(imsm_pkg::BIT_CYCLES - 1)) begin
                next_s.baud = 9'h0;
                if (s.bit_idx == 4'(imsm_pkg::FRAME_BITS - 1)) begin
                    next_s.bit_idx = 4'h0;
                    next_s.byte_idx = s.byte_idx + 7'h1;
                    if (s.byte_idx == 7'(imsm_pkg::MSG_BYTES - 1)) begin
                        next_s.busy = 1'b0;
                        next_s.byte_idx = 7'h0;
                        next_s.count = s.count + 16'h1;
                    end
                end else begin
                    next_s.bit_idx = s.bit_idx + 4'h1;
                end
            end else begin
                next_s.baud = s.baud + 9'h1;
            end
        end
        if (!next_s.busy) begin
            next_s.tx_line = 1'b1;
        end else if (next_s.bit_idx == 4'h0) begin
            next_s.tx_line = 1'b0;
        end else if (next_s.bit_idx <= 4'(imsm_pkg::DATA_BITS)) begin
            next_s.tx_line = cur_byte[3'(next_s.bit_idx - 4'h1)];
        end else begin
            next_s.tx_line = 1'b1;
        end

        // host reset pin low holds everything idle
        if (!s.run) begin
            next_s = IDLE_STATE;
            next_s.gate_sync = {s.gate_sync[1:0], link.gate_level};
            next_s.gate_en = s.gate_en;
            next_s.rst_sync = {s.rst_sync[1:0], link.reset_pin_n};
            next_s.run = (s.rst_sync[2] == s.rst_sync[1]) ? s.rst_sync[2] : s.run;
            // first period after release gets a full-width strobe
            next_s.strobe = next_s.run;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s <= IDLE_STATE;
        end else begin
            s <= next_s;
        end
    end

    assign link.serial_out_pos = s.tx_line;
    assign link.serial_out_neg = ~s.tx_line;
    assign link.sample_strobe = s.strobe;
    assign slot = s.slot;
    assign sending = s.busy;
endmodule // imsm_device
`default_nettype wire

//--- rtl/imsm_pkg.sv
/*
 imsm_pkg: constants shared by both ends of the serial message link.
 assumes a single 125 MHz clock on each end.
*/
`default_nettype none
package imsm_pkg;
    localparam int unsigned CLK_HZ = 125_000_000;
    localparam int unsigned CLK_MHZ = 125;
    localparam int unsigned BAUD = 460_800;
    // bit period, nearest whole cycle
    localparam int unsigned BIT_CYCLES = (CLK_HZ + BAUD / 2) / BAUD;
    localparam int unsigned HALF_BIT_CYCLES = BIT_CYCLES / 2;
    localparam int unsigned DATA_BITS = 8;
    localparam int unsigned STOP_BITS = 2;
    localparam int unsigned FRAME_BITS = 1 + DATA_BITS + STOP_BITS;
    localparam int unsigned SAMPLE_HZ = 1_000;
    localparam int unsigned SAMPLE_PERIOD_US = 1_000;
    localparam int unsigned STROBE_US = 190;
    localparam int unsigned SAMPLE_PERIOD_CYCLES = SAMPLE_PERIOD_US * CLK_MHZ;
    localparam int unsigned STROBE_CYCLES = STROBE_US * CLK_MHZ;
    localparam int unsigned SLOTS = 5;
    localparam logic [2:0] SLOT_FIRST = 3'h1;
    localparam logic [2:0] SLOT_COMP_CALC = 3'h2;
    localparam logic [2:0] SLOT_COMP_APPLY = 3'h3;
    localparam logic [2:0] SLOT_TRANSMIT = 3'h5;
    localparam int unsigned MSG_WORDS = 34;
    localparam int unsigned MSG_BYTES = 68;
    localparam int unsigned CHANNELS = 6;
    localparam int unsigned FLAG_WORDS = 3;
    localparam int unsigned FLAG_FIRST_WORD = 30;
    localparam int unsigned DATA_FIRST_WORD = 2;
    localparam logic [15:0] HEADER = 16'h55AA;
    localparam int unsigned FILTER_SHIFT = 1;
endpackage
`default_nettype wire

//--- rtl/imsm_link_if.sv
/*
 imsm_link_if: pins between the measurement unit and its host.
 assumes the gate pin floats high when the host does not drive it.
*/
`timescale 1ns/10ps
`default_nettype none
interface imsm_link_if;
    logic serial_out_pos;
    logic serial_out_neg;
    logic sample_strobe;
    logic gate_drive;
    logic gate_oe_n;
    logic gate_level;
    logic reset_pin_n;
    // pull-up: floating gate reads high
    assign gate_level = gate_oe_n ? 1'b1 : gate_drive;
    modport device (
        output serial_out_pos,
        output serial_out_neg,
        output sample_strobe,
        input gate_level,
        input reset_pin_n
    );
    modport host (
        input serial_out_pos,
        input serial_out_neg,
        input sample_strobe,
        output gate_drive,
        output gate_oe_n,
        output reset_pin_n
    );
endinterface
`default_nettype wire

//--- rtl/imsm_host.sv
/*
 imsm_host: host end; drives reset and gate pins, receives and checks messages.
 assumes link pins are asynchronous to clk.
*/
`timescale 1ns/10ps
`default_nettype none
module imsm_host (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // user side
    input wire logic hold_reset,
    input wire logic output_enable,
    output logic msg_done,
    output logic msg_ok,
    output logic [15:0] msg_count,
    output logic frame_err,
    output logic strobe_rise,
    // pins
    imsm_link_if.host link
);
    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_START = 2'b01,
        RX_DATA = 2'b10,
        RX_STOP = 2'b11
    } imsm_rx_type;

    typedef struct packed {
        logic [2:0] line_sync;
        logic line;
        logic [2:0] strobe_sync;
        logic strobe;
        imsm_rx_type state;
        logic [8:0] baud;
        logic [2:0] bit_idx;
        logic [7:0] shreg;
        logic [7:0] hi_byte;
        logic byte_phase;
        logic [5:0] word_idx;
        logic [15:0] sum;
        logic [15:0] count;
        logic done;
        logic ok;
        logic ferr;
        logic rise;
        logic gate_oe_n;
        logic reset_pin_n;
    } imsm_host_type;

    localparam imsm_host_type IDLE_STATE = '{
        line_sync: 3'h7, line: 1'b1, strobe_sync: 3'h0, strobe: 1'b0,
        state: RX_IDLE, baud: 9'h0, bit_idx: 3'h0, shreg: 8'h0, hi_byte: 8'h0,
        byte_phase: 1'b0, word_idx: 6'h0, sum: 16'h0, count: 16'h0, done: 1'b0,
        ok: 1'b0, ferr: 1'b0, rise: 1'b0, gate_oe_n: 1'b1, reset_pin_n: 1'b0};

    imsm_host_type s;
    imsm_host_type next_s;
    logic [15:0] word;

    always_comb begin
        next_s = s;
        word = {s.hi_byte, s.shreg};
        next_s.done = 1'b0;
        next_s.ferr = 1'b0;
        next_s.rise = 1'b0;
        next_s.reset_pin_n = ~hold_reset;
        next_s.gate_oe_n = output_enable;
        next_s.line_sync = {s.line_sync[1:0], link.serial_out_pos};
        if (s.line_sync[2] == s.line_sync[1]) begin
            next_s.line = s.line_sync[2];
        end
        next_s.strobe_sync = {s.strobe_sync[1:0], link.sample_strobe};
        if (s.strobe_sync[2] == s.strobe_sync[1]) begin
            next_s.strobe = s.strobe_sync[2];
            next_s.rise = s.strobe_sync[2] & ~s.strobe;
        end
        next_s.baud = s.baud + 9'h1;
        case (s.state)
            RX_IDLE: begin
                next_s.baud = 9'h0;
                if (!s.line) begin
                    next_s.state = RX_START;
                end
            end
            RX_START: begin
                if (s.baud == 9'(imsm_pkg::HALF_BIT_CYCLES - 1)) begin
                    next_s.baud = 9'h0;
                    next_s.bit_idx = 3'h0;
                    next_s.state = s.line ? RX_IDLE : RX_DATA;
                end
            end
            RX_DATA: begin
                if (s.baud == 9'(imsm_pkg::BIT_CYCLES - 1)) begin
                    next_s.baud = 9'h0;
                    next_s.shreg = {s.line, s.shreg[7:1]};
                    next_s.bit_idx = s.bit_idx + 3'h1;
                    if (s.bit_idx == 3'(imsm_pkg::DATA_BITS - 1)) begin
                        next_s.state = RX_STOP;
                    end
                end
            end
            RX_STOP: begin
                if (s.baud == 9'(imsm_pkg::BIT_CYCLES - 1)) begin
                    next_s.state = RX_IDLE;
                    if (!s.line) begin
                        next_s.ferr = 1'b1;
                    end else if (!s.byte_phase) begin
                        next_s.hi_byte = s.shreg;
                        next_s.byte_phase = 1'b1;
                    end else begin
                        next_s.byte_phase = 1'b0;
                        if (s.word_idx == 6'h0 && word != imsm_pkg::HEADER) begin
                            next_s.word_idx = 6'h0;
                        end else if (s.word_idx == 6'(imsm_pkg::MSG_WORDS - 1)) begin
                            next_s.done = 1'b1;
                            next_s.ok = (s.sum + word) == 16'h0;
                            next_s.word_idx = 6'h0;
                            next_s.sum = 16'h0;
                        end else begin
                            if (s.word_idx == 6'h1) begin
                                next_s.count = word;
                            end
                            next_s.sum = s.sum + word;
                            next_s.word_idx = s.word_idx + 6'h1;
                        end
                    end
                end
            end
            default: begin
                next_s.state = RX_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s <= IDLE_STATE;
        end else begin
            s <= next_s;
        end
    end

    assign link.gate_drive = 1'b0;
    assign link.gate_oe_n = s.gate_oe_n;
    assign link.reset_pin_n = s.reset_pin_n;
    assign msg_done = s.done;
    assign msg_ok = s.ok;
    assign msg_count = s.count;
    assign frame_err = s.ferr;
    assign strobe_rise = s.rise;
endmodule // imsm_host
`default_nettype wire

//--- dv/imsm_link_checker.sv
/*
 imsm_link_checker: assertions on the pins between unit and host.
 assumes the bench instantiates it beside the link interface.
*/
`timescale 1ns/10ps
`default_nettype none
module imsm_link_checker #(
    parameter int unsigned PERIOD_CYCLES = 41000,
    parameter int unsigned STROBE_LEN = 300
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // link pins
    input wire logic serial_out_pos,
    input wire logic serial_out_neg,
    input wire logic sample_strobe,
    input wire logic gate_drive,
    input wire logic gate_oe_n,
    input wire logic gate_level,
    input wire logic reset_pin_n
);
    localparam int BITC = 271;
    localparam int GAP = 2710;
    typedef struct packed {
        logic pos;
        logic seen_stb;
        logic seen_msg;
        logic [31:0] lo, hi, stb_hi, stb_lo, since, nbytes, frame;
        logic [7:0] gate_lo;
    } imsm_chk_state_type;
    imsm_chk_state_type st;
    imsm_chk_state_type next_st;
    logic fall;
    logic start_bit;
    logic msg_start;
    assign fall = st.pos && !serial_out_pos;
    // data falls are skipped until the frame timer runs out
    assign start_bit = fall && (st.frame == 32'h0);
    assign msg_start = start_bit && (st.hi > GAP);
    always_comb begin
        next_st = st;
        next_st.pos = serial_out_pos;
        next_st.lo = serial_out_pos ? 32'h0 : st.lo + 32'h1;
        next_st.hi = serial_out_pos ? st.hi + 32'h1 : 32'h0;
        next_st.stb_hi = sample_strobe ? st.stb_hi + 32'h1 : 32'h0;
        next_st.stb_lo = sample_strobe ? 32'h0 : st.stb_lo + 32'h1;
        next_st.seen_stb = reset_pin_n && (st.seen_stb || (st.stb_hi != 32'h0 && !sample_strobe));
        next_st.seen_msg = st.seen_msg || msg_start;
        next_st.since = msg_start ? 32'h1 : st.since + 32'h1;
        next_st.nbytes = msg_start ? 32'h1 : st.nbytes + {31'h0, start_bit};
        next_st.frame = start_bit ? 32'(10 * BITC) : st.frame - {31'h0, st.frame != 32'h0};
        next_st.gate_lo = gate_level ? 8'h0 : st.gate_lo + {7'h0, st.gate_lo != 8'hFF};
    end
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st <= '0;
            st.pos <= 1'b1;
        end else begin
            st <= next_st;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    sequence s_msg_start;
        msg_start;
    endsequence
    sequence s_stb_end;
        $fell(sample_strobe);
    endsequence
    AST_PAIR_INVERSE: assert property (serial_out_neg == !serial_out_pos)
        else $error("serial pair not complementary");
    AST_BIT_MULTIPLE: assert property (!st.pos && serial_out_pos |-> (st.lo % BITC) == 0)
        else $error("low run not whole bit periods");
    AST_STOP_BITS: assert property (start_bit |-> st.hi >= 2 * BITC)
        else $error("start bit without two stop bits before it");
    AST_MSG_BYTES: assert property (st.seen_msg && st.hi == 11 * BITC |-> st.nbytes == 68)
        else $error("message byte count wrong");
    AST_MSG_SPACING: assert property (s_msg_start and st.seen_msg |-> st.since == 5 * PERIOD_CYCLES)
        else $error("message spacing wrong");
    AST_AFTER_STROBE: assert property (s_msg_start |-> !sample_strobe && st.stb_lo inside {[1:6]})
        else $error("message not started just after strobe fall");
    AST_GATE_STOPS: assert property (s_msg_start |-> st.gate_lo < 8'h08)
        else $error("message started with gate held low");
    AST_STROBE_WIDTH: assert property (s_stb_end |-> st.stb_hi == STROBE_LEN)
        else $error("strobe width wrong");
    AST_STROBE_PERIOD: assert property ($rose(sample_strobe) && st.seen_stb |->
        st.stb_lo == PERIOD_CYCLES - STROBE_LEN)
        else $error("strobe period wrong");
    AST_RESET_IDLE: assert property ((!reset_pin_n) [*8] |-> serial_out_pos && !sample_strobe)
        else $error("unit active while reset pin low");
    AST_GATE_PULL: assert property (gate_level == (gate_oe_n || gate_drive))
        else $error("gate pin level not pulled or driven as expected");
endmodule // imsm_link_checker
`default_nettype wire

//--- dv/imsm_link_bench.sv
/*
 imsm_link_bench: joins unit and host, decodes the wire and checks messages.
 assumes design files and checker are compiled before it.
*/
`timescale 1ns/10ps
`default_nettype none
module imsm_link_bench;
    localparam int PER = 41000;
    localparam int STB = 300;
    localparam int BITC = 271;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [imsm_pkg::CHANNELS-1:0][15:0] sensor_in = {6{16'h0100}};
    logic [15:0] comp_bias = 16'h0010;
    logic [2:0][15:0] flag_words = {16'h0F0F, 16'hA5A5, 16'h1234};
    logic hold_reset = 1'b1;
    logic output_enable = 1'b1;
    logic [2:0] slot;
    logic sending, msg_done, msg_ok, frame_err, strobe_rise;
    logic [15:0] msg_count;
    logic [15:0] words [0:33];
    logic [2:0] rows [0:4] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5};
    int errors = 0;
    int n_checks = 0;
    int cyc = 0;
    int t_prev = 0;
    int n_done = 0;
    int n_ferr = 0;
    int n_rise = 0;
    wire logic line;
    wire logic stb;
    imsm_link_if imsm_link_if_i ();
    assign line = imsm_link_if_i.serial_out_pos;
    assign stb = imsm_link_if_i.sample_strobe;
    imsm_device #(.PERIOD_CYCLES(PER), .STROBE_LEN(STB)) imsm_device_i (.clk(clk), .reset(reset),
        .sensor_in(sensor_in), .comp_bias(comp_bias), .flag_words(flag_words), .slot(slot),
        .sending(sending), .link(imsm_link_if_i.device));
    imsm_host imsm_host_i (.clk(clk), .reset(reset), .hold_reset(hold_reset),
        .output_enable(output_enable), .msg_done(msg_done), .msg_ok(msg_ok),
        .msg_count(msg_count), .frame_err(frame_err), .strobe_rise(strobe_rise),
        .link(imsm_link_if_i.host));
    imsm_link_checker #(.PERIOD_CYCLES(PER), .STROBE_LEN(STB)) imsm_link_checker_i (.clk(clk),
        .reset(reset), .serial_out_pos(line), .serial_out_neg(imsm_link_if_i.serial_out_neg),
        .sample_strobe(stb), .gate_drive(imsm_link_if_i.gate_drive),
        .gate_oe_n(imsm_link_if_i.gate_oe_n), .gate_level(imsm_link_if_i.gate_level),
        .reset_pin_n(imsm_link_if_i.reset_pin_n));
    always #4 clk = ~clk;
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        n_done <= n_done + int'(msg_done);
        n_ferr <= n_ferr + int'(frame_err);
        n_rise <= n_rise + int'(strobe_rise);
        if (cyc == 650000) begin
            errors++;
            tally_and_finish();
        end
    end
    task automatic check1(input string what, input logic exp, input logic got);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic check32(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wait_for(input bit which, input logic lvl, input int lim);
        logic v;
        v = ~lvl;
        for (int k = 0; k < lim && v !== lvl; k++) begin
            @(posedge clk);
            v = which ? stb : line;
        end
        check1("wait level", lvl, v);
    endtask
    task automatic rx_byte(output logic [7:0] b);
        repeat (BITC / 2) @(posedge clk);
        check1("start bit", 1'b0, line);
        for (int k = 0; k < 8; k++) begin
            repeat (BITC) @(posedge clk);
            b[k] = line;
        end
        repeat (BITC) @(posedge clk);
        check1("stop bit one", 1'b1, line);
        repeat (BITC) @(posedge clk);
        check1("stop bit two", 1'b1, line);
    endtask
    task automatic rx_msg(input int first_lim, input int drop, input logic [15:0] exp_count,
        input logic [15:0] exp_data);
        logic [7:0] b;
        logic [15:0] sum;
        sum = 16'h0000;
        for (int j = 0; j < 68; j++) begin
            wait_for(1'b0, 1'b0, j ? 300 : first_lim);
            if (j == 0) begin
                check1("strobe low at start", 1'b0, stb);
                if (t_prev != 0) check32("spacing", 32'(5 * PER), 32'(cyc - t_prev));
                t_prev = cyc;
            end
            rx_byte(b);
            check1("sending", 1'b1, sending);
            words[j / 2] = (j % 2) ? {words[j / 2][15:8], b} : {b, 8'h00};
            if (j == drop) output_enable <= 1'b0;
        end
        for (int k = 0; k < 34; k++) sum += words[k];
        check32("header", 32'h55AA, 32'(words[0]));
        check32("count word", 32'(exp_count), 32'(words[1]));
        for (int k = 0; k < 3; k++) check32("flags", 32'(flag_words[k]), 32'(words[30 + k]));
        check32("checksum sum", 32'h0, 32'(sum));
        for (int k = 0; k < 6; k++) begin
            check32("data high", 32'h0, 32'(words[2 + 2 * k]));
            check32("data low", 32'(exp_data), 32'(words[3 + 2 * k]));
        end
        repeat (300) @(posedge clk);
        check1("host checksum", 1'b1, msg_ok);
        check32("host count", 32'(exp_count), 32'(msg_count));
    endtask
    initial begin
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        repeat (20) @(posedge clk);
        check1("line idle held", 1'b1, line);
        check1("strobe held", 1'b0, stb);
        check32("slot held", 32'h1, 32'(slot));
        check1("gate floats high", 1'b1, imsm_link_if_i.gate_level);
        hold_reset <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            check32("strobe rises", 32'(i), 32'(n_rise));
            wait_for(1'b1, 1'b1, PER + 100);
            repeat (2) @(posedge clk);
            check32("slot", 32'(rows[i]), 32'(slot));
            check1("idle in slot", 1'b0, sending);
            if (i < 4) wait_for(1'b1, 1'b0, STB + 10);
        end
        // filtered 0x0100 after three and eight periods, plus bias 0x0010
        rx_msg(STB + 50, 99, 16'h0000, 16'h0103);
        rx_msg(5 * PER, 10, 16'h0001, 16'h010E);
        check1("gate driven low", 1'b0, imsm_link_if_i.gate_level);
        repeat (3000) @(posedge clk);
        check1("line idle gated", 1'b1, line);
        check1("no message gated", 1'b0, sending);
        hold_reset <= 1'b1;
        repeat (20) @(posedge clk);
        check1("strobe held mid run", 1'b0, stb);
        check32("slot held mid run", 32'h1, 32'(slot));
        check32("messages done", 32'h2, 32'(n_done));
        check32("frame errors", 32'h0, 32'(n_ferr));
        tally_and_finish();
    end
endmodule // imsm_link_bench
`default_nettype wire
